// >>> rtl/direct_frequency_cmd_sweep.sv
// Purpose: frequency sweep sequencer with range derivation and sync link
// Assumes: all inputs synchronous to hclk; one AHB-Lite master
// Notes: one sweep step per clock, sweep time given in steps
// Summary of operation
// RULE_01: start below stop sweeps upward from start toward stop.
// RULE_02: start above stop sweeps downward from start toward stop.
// RULE_03: writing start keeps stop, center is truncated half-sum, span absolute difference.
// RULE_04: writing stop keeps start, recomputes center and span likewise.
// RULE_05: writing center keeps span and direction, low and high ends are center minus/plus half span.
// RULE_06: writing span keeps center and direction, recomputes start and stop.
// RULE_07: odd span makes reported center half a unit low.
// RULE_08: triangle ramps up and down each one sweep time.
// RULE_09: sawtooth ramps start to stop in one sweep time, then repeats.
// RULE_10: square holds start one sweep time then stop one sweep time.
// RULE_11: continuous sweep rejects direct frequency programming until turned off.
// RULE_12: single sweep runs once; frequency programming blocked during it only.
// RULE_13: single sweep end sets marker and sync high, drive to zero.
// RULE_14: hold freezes frequency and all three outputs at once.
// RULE_15: second hold resumes from held point; programming stays blocked.
// RULE_16: sweep off ends sweep or hold, flags high, drive zero.
// RULE_17: off or frequency command in end/start/stop state enables programming, flags high, drive zero.
// RULE_18: start state outputs start, flags high, drive zero upward, full downward.
// RULE_19: frequency command in start state leaves it and sets drive zero.
// RULE_20: master sends clock and phase-sync pulses on the sync link.
// RULE_21: slave takes clock and phase-sync from master, ignores own phase-sync commands; sync_clock_in is left unused.
// RULE_22: operator issues phase-sync on master after setting waveforms and frequencies.
// RULE_23: stop state outputs stop, flags high, drive full upward, zero downward.
// RULE_24: falling edge of external single trigger starts a single sweep; idles high.
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module direct_frequency_cmd_sweep #(
  parameter int direct_frequency_cmd_w = sweep_pkg::direct_frequency_cmd_w
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic continuous_sweep_cmd,
  input wire logic single_sweep_cmd,
  input wire logic hold_resume_cmd,
  input wire logic sweep_off_cmd,
  input wire logic start_state_cmd,
  input wire logic stop_state_cmd,
  input wire logic direct_frequency_cmd,
  input wire logic host_phase_align_cmd,
  input wire logic ext_single_trigger,
  input wire logic [direct_frequency_cmd_w-1:0] direct_frequency,
  input wire logic sync_clock_in,
  input wire logic sync_phase_in,
  output logic sync_clock_out,
  output logic sync_clock_oe,
  output logic sync_phase_out,
  output logic sync_phase_oe,
  output logic phase_restart,
  output logic [direct_frequency_cmd_w-1:0] out_frequency,
  output logic marker_flag,
  output logic sweep_sync_flag,
  output logic [sweep_pkg::drive_w-1:0] horizontal_drive,
  output logic program_enable
);
  // bus address phase capture
  logic wr_pend;
  logic [7:0] wr_addr;
  wire logic bus_take = hsel && htrans[1] && hready;
  wire logic bus_wr = bus_take && hwrite;
  wire logic [7:0] bus_addr = {haddr[7:2], 2'b00};
  wire logic wr_start = wr_pend && wr_addr == sweep_pkg::off_start;
  wire logic wr_stop = wr_pend && wr_addr == sweep_pkg::off_stop;
  wire logic wr_center = wr_pend && wr_addr == sweep_pkg::off_center;
  wire logic wr_span = wr_pend && wr_addr == sweep_pkg::off_span;
  wire logic wr_time = wr_pend && wr_addr == sweep_pkg::off_time;
  wire logic wr_ctrl = wr_pend && wr_addr == sweep_pkg::off_ctrl;
  wire logic wr_cmd = wr_pend && wr_addr == sweep_pkg::off_cmd;
  wire logic wr_direct_frequency_cmd = wr_pend && wr_addr == sweep_pkg::off_direct_frequency_cmd;
  wire logic [sweep_pkg::cmd_w-1:0] bus_cmd = wr_cmd ? hwdata[sweep_pkg::cmd_w-1:0] : '0;

  // range registers
  logic [direct_frequency_cmd_w-1:0] start_f;
  logic [direct_frequency_cmd_w-1:0] stop_f;
  logic [direct_frequency_cmd_w-1:0] center_f;
  logic [direct_frequency_cmd_w-1:0] span_f;
  logic [31:0] sweep_time;
  logic [1:0] shape;
  logic slave_mode;
  wire logic [direct_frequency_cmd_w-1:0] new_val = hwdata[direct_frequency_cmd_w-1:0];
  wire logic upward = start_f < stop_f; // RULE_01 RULE_02
  wire logic [direct_frequency_cmd_w:0] sum_ss_start = {1'b0, new_val} + {1'b0, stop_f};
  wire logic [direct_frequency_cmd_w:0] sum_ss_stop = {1'b0, start_f} + {1'b0, new_val};
  wire logic [direct_frequency_cmd_w-1:0] diff_start = new_val > stop_f ? new_val - stop_f : stop_f - new_val;
  wire logic [direct_frequency_cmd_w-1:0] diff_stop = start_f > new_val ? start_f - new_val : new_val - start_f;
  wire logic [direct_frequency_cmd_w-1:0] half_span = span_f >> 1;
  wire logic [direct_frequency_cmd_w-1:0] half_new = new_val >> 1;
  // odd span: low end is center minus half, high end gets the extra unit
  wire logic [direct_frequency_cmd_w-1:0] hi_c = new_val + span_f - half_span;
  wire logic [direct_frequency_cmd_w-1:0] lo_c = new_val - half_span;
  wire logic [direct_frequency_cmd_w-1:0] hi_s = center_f + new_val - half_new;
  wire logic [direct_frequency_cmd_w-1:0] lo_s = center_f - half_new;

  // command decode, key or bus
  logic trig_prev;
  wire logic ext_fall = trig_prev && !ext_single_trigger; // RULE_24
  wire logic c_cont = continuous_sweep_cmd || bus_cmd[sweep_pkg::cmd_cont];
  wire logic c_single = single_sweep_cmd || bus_cmd[sweep_pkg::cmd_single] || ext_fall; // RULE_24
  wire logic c_hold = hold_resume_cmd || bus_cmd[sweep_pkg::cmd_hold];
  wire logic c_off = sweep_off_cmd || bus_cmd[sweep_pkg::cmd_off];
  wire logic c_start_st = start_state_cmd || bus_cmd[sweep_pkg::cmd_start_st];
  wire logic c_stop_st = stop_state_cmd || bus_cmd[sweep_pkg::cmd_stop_st];
  wire logic c_direct_frequency_cmd = direct_frequency_cmd || wr_direct_frequency_cmd;
  wire logic c_phase = !slave_mode && (host_phase_align_cmd || bus_cmd[sweep_pkg::cmd_phase]); // RULE_21

  // sweep engine
  sweep_pkg::state_t state;
  sweep_pkg::state_t next_state;
  logic single_run;
  logic second_half;
  logic [31:0] step;
  logic [direct_frequency_cmd_w-1:0] fixed_direct_frequency_cmd;
  wire logic sweeping = state == sweep_pkg::st_run || state == sweep_pkg::st_hold;
  wire logic allow_prog = !sweeping; // RULE_11 RULE_12 RULE_15
  wire logic last_step = step + 32'h0000_0001 >= sweep_time;
  wire logic shape_tri = shape == 2'(sweep_pkg::shape_triangle);
  wire logic shape_sq = shape == 2'(sweep_pkg::shape_square);
  wire logic [direct_frequency_cmd_w-1:0] span_abs = upward ? stop_f - start_f : start_f - stop_f;
  wire logic [direct_frequency_cmd_w+31:0] prod = span_abs * step;
  wire logic [direct_frequency_cmd_w-1:0] delta = sweep_time == 32'h0 ? '0 : direct_frequency_cmd_w'(prod / sweep_time);
  wire logic descending_leg = shape_tri && second_half; // RULE_08
  wire logic [direct_frequency_cmd_w-1:0] from_f = descending_leg ? stop_f : start_f;
  wire logic dir_up = descending_leg ? !upward : upward;
  wire logic [direct_frequency_cmd_w-1:0] ramp_f = dir_up ? from_f + delta : from_f - delta;
  wire logic [direct_frequency_cmd_w-1:0] sweep_f = shape_sq ? (second_half ? stop_f : start_f) : ramp_f; // RULE_10
  wire logic [sweep_pkg::drive_w+31:0] dprod = {{sweep_pkg::drive_w{1'b0}}, step} * 32'(sweep_pkg::drive_full);
  wire logic [sweep_pkg::drive_w-1:0] ramp_drive =
    sweep_time == 32'h0 ? '0 : sweep_pkg::drive_w'(dprod / sweep_time);
  wire logic [sweep_pkg::drive_w-1:0] drive_run = descending_leg ? sweep_pkg::drive_full - ramp_drive : ramp_drive;
  wire logic end_of_leg = state == sweep_pkg::st_run && last_step;
  wire logic leg_second = shape_tri || shape_sq;
  wire logic sweep_done = end_of_leg && (!leg_second || second_half);

  always_comb
  begin
    next_state = state;
    unique case (state)
      sweep_pkg::st_off:
        next_state = state;
      sweep_pkg::st_run:
        if (c_hold)
          next_state = sweep_pkg::st_hold; // RULE_14
        else if (sweep_done && single_run)
          next_state = sweep_pkg::st_single_end; // RULE_12
      sweep_pkg::st_hold:
        if (c_hold)
          next_state = sweep_pkg::st_run; // RULE_15
      sweep_pkg::st_single_end, sweep_pkg::st_start_state, sweep_pkg::st_stop_state:
        if (c_direct_frequency_cmd)
          next_state = sweep_pkg::st_off; // RULE_17 RULE_19
    endcase
    if (c_off)
      next_state = sweep_pkg::st_off; // RULE_16 RULE_17
    else if (c_cont || c_single)
      next_state = sweep_pkg::st_run;
    else if (c_start_st)
      next_state = sweep_pkg::st_start_state;
    else if (c_stop_st)
      next_state = sweep_pkg::st_stop_state;
  end

  // sync link pacing
  logic [7:0] pulse_cnt;
  logic [1:0] clk_div;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      start_f <= direct_frequency_cmd_w'(sweep_pkg::rst_start);
      stop_f <= direct_frequency_cmd_w'(sweep_pkg::rst_stop);
      center_f <= direct_frequency_cmd_w'((sweep_pkg::rst_start + sweep_pkg::rst_stop) >> 1);
      span_f <= direct_frequency_cmd_w'(sweep_pkg::rst_stop - sweep_pkg::rst_start);
      sweep_time <= sweep_pkg::rst_time;
      shape <= 2'(sweep_pkg::shape_triangle);
      slave_mode <= 1'b0;
      trig_prev <= 1'b1;
      state <= sweep_pkg::st_off;
      single_run <= 1'b0;
      second_half <= 1'b0;
      step <= 32'h0000_0000;
      fixed_direct_frequency_cmd <= '0;
      out_frequency <= '0;
      marker_flag <= 1'b1;
      sweep_sync_flag <= 1'b1;
      horizontal_drive <= sweep_pkg::drive_zero;
      program_enable <= 1'b1;
      pulse_cnt <= 8'h00;
      clk_div <= 2'b00;
      sync_clock_out <= 1'b0;
      sync_clock_oe <= 1'b0;
      sync_phase_out <= 1'b0;
      sync_phase_oe <= 1'b0;
      phase_restart <= 1'b0;
    end
    else
    begin
      wr_pend <= bus_wr;
      wr_addr <= bus_addr;
      trig_prev <= ext_single_trigger;
      if (bus_take && !hwrite)
      begin
        unique case (bus_addr)
          sweep_pkg::off_start: hrdata <= 32'(start_f);
          sweep_pkg::off_stop: hrdata <= 32'(stop_f);
          sweep_pkg::off_center: hrdata <= 32'(center_f); // RULE_07
          sweep_pkg::off_span: hrdata <= 32'(span_f);
          sweep_pkg::off_time: hrdata <= sweep_time;
          sweep_pkg::off_ctrl: hrdata <= {29'h0, slave_mode, shape};
          sweep_pkg::off_status: hrdata <= {28'h0, single_run, state};
          sweep_pkg::off_direct_frequency_cmd: hrdata <= 32'(out_frequency);
          sweep_pkg::off_out: hrdata <= {20'h0, marker_flag, sweep_sync_flag, horizontal_drive};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
      if (wr_start)
      begin
        start_f <= new_val; // RULE_03
        center_f <= sum_ss_start[direct_frequency_cmd_w:1];
        span_f <= diff_start;
      end
      if (wr_stop)
      begin
        stop_f <= new_val; // RULE_04
        center_f <= sum_ss_stop[direct_frequency_cmd_w:1];
        span_f <= diff_stop;
      end
      if (wr_center)
      begin
        center_f <= new_val; // RULE_05
        start_f <= upward ? lo_c : hi_c;
        stop_f <= upward ? hi_c : lo_c;
      end
      if (wr_span)
      begin
        span_f <= new_val; // RULE_06
        start_f <= upward ? lo_s : hi_s;
        stop_f <= upward ? hi_s : lo_s;
      end
      if (wr_time)
        sweep_time <= hwdata;
      if (wr_ctrl)
      begin
        shape <= hwdata[sweep_pkg::ctrl_shape_lsb +: 2];
        slave_mode <= hwdata[sweep_pkg::ctrl_slave_bit];
      end
      state <= next_state;
      program_enable <= next_state == sweep_pkg::st_off || next_state == sweep_pkg::st_single_end;
      if (c_direct_frequency_cmd && allow_prog)
        fixed_direct_frequency_cmd <= wr_direct_frequency_cmd ? new_val : direct_frequency; // RULE_11 RULE_12
      if ((c_cont || c_single) && !c_off)
      begin
        single_run <= c_single;
        step <= 32'h0000_0000;
        second_half <= 1'b0;
      end
      else if (state == sweep_pkg::st_run && next_state == sweep_pkg::st_run)
      begin
        step <= last_step ? 32'h0000_0000 : step + 32'h0000_0001; // RULE_09
        if (end_of_leg)
          second_half <= leg_second && !second_half;
      end
      unique case (next_state)
        sweep_pkg::st_run:
        begin
          out_frequency <= sweep_f;
          marker_flag <= sweep_f > center_f;
          sweep_sync_flag <= second_half;
          horizontal_drive <= drive_run;
        end
        sweep_pkg::st_hold:
          out_frequency <= out_frequency; // RULE_14
        sweep_pkg::st_single_end:
        begin
          marker_flag <= 1'b1; // RULE_13
          sweep_sync_flag <= 1'b1;
          horizontal_drive <= sweep_pkg::drive_zero;
        end
        sweep_pkg::st_start_state:
        begin
          out_frequency <= start_f; // RULE_18
          marker_flag <= 1'b1;
          sweep_sync_flag <= 1'b1;
          horizontal_drive <= upward ? sweep_pkg::drive_zero : sweep_pkg::drive_full;
        end
        sweep_pkg::st_stop_state:
        begin
          out_frequency <= stop_f; // RULE_23
          marker_flag <= 1'b1;
          sweep_sync_flag <= 1'b1;
          horizontal_drive <= upward ? sweep_pkg::drive_full : sweep_pkg::drive_zero;
        end
        sweep_pkg::st_off:
        begin
          out_frequency <= (c_direct_frequency_cmd && allow_prog) ? (wr_direct_frequency_cmd ? new_val : direct_frequency) : fixed_direct_frequency_cmd;
          marker_flag <= 1'b1; // RULE_16 RULE_17 RULE_19
          sweep_sync_flag <= 1'b1;
          horizontal_drive <= sweep_pkg::drive_zero;
        end
        default:
          out_frequency <= fixed_direct_frequency_cmd;
      endcase
      // master drives clock and phase pulse, slave listens
      clk_div <= clk_div + 2'b01;
      sync_clock_oe <= !slave_mode; // RULE_20
      sync_phase_oe <= !slave_mode;
      sync_clock_out <= !slave_mode && clk_div[1];
      if (c_phase)
        pulse_cnt <= 8'(sweep_pkg::sync_pulse_cycles);
      else if (pulse_cnt != 8'h00)
        pulse_cnt <= pulse_cnt - 8'h01;
      sync_phase_out <= !slave_mode && (c_phase || pulse_cnt != 8'h00); // RULE_20
      phase_restart <= slave_mode ? sync_phase_in : c_phase; // RULE_21
    end
  end
endmodule // direct_frequency_cmd_sweep

// >>> rtl/sweep_pkg.sv
// Purpose: shared constants and types for the frequency sweep controller
// Assumes: frequencies are unsigned counts of 0.1 mHz units
// Notes: register map is word aligned on an AHB-Lite slave
package sweep_pkg;
  localparam int direct_frequency_cmd_w = 32;
  localparam int drive_w = 10;
  // register byte offsets
  localparam logic [7:0] off_start = 8'h00;
  localparam logic [7:0] off_stop = 8'h04;
  localparam logic [7:0] off_center = 8'h08;
  localparam logic [7:0] off_span = 8'h0C;
  localparam logic [7:0] off_time = 8'h10;
  localparam logic [7:0] off_ctrl = 8'h14;
  localparam logic [7:0] off_cmd = 8'h18;
  localparam logic [7:0] off_status = 8'h1C;
  localparam logic [7:0] off_direct_frequency_cmd = 8'h20;
  localparam logic [7:0] off_out = 8'h24;
  // ctrl field positions
  localparam int ctrl_shape_lsb = 0;
  localparam int ctrl_slave_bit = 2;
  // cmd bit positions
  localparam int cmd_cont = 0;
  localparam int cmd_single = 1;
  localparam int cmd_hold = 2;
  localparam int cmd_off = 3;
  localparam int cmd_start_st = 4;
  localparam int cmd_stop_st = 5;
  localparam int cmd_phase = 6;
  localparam int cmd_w = 7;
  // reset values, drive levels and sync pulse length
  localparam logic [31:0] rst_start = 32'h0000_2710;
  localparam logic [31:0] rst_stop = 32'h0001_86A0;
  localparam logic [31:0] rst_time = 32'h0000_0100;
  localparam logic [9:0] drive_zero = 10'h000;
  localparam logic [9:0] drive_full = 10'h3FF;
  localparam int sync_pulse_cycles = 4;
  typedef enum logic [1:0] {shape_triangle, shape_sawtooth, shape_square} shape_t;
  typedef enum logic [2:0] {st_off, st_run, st_hold, st_single_end, st_start_state, st_stop_state} state_t;
endpackage

// >>> testbench/direct_frequency_cmd_sweep_sva.sv
// Purpose: port checks of the sweep controller
// Assumes: commands are one-cycle pulses on hclk
// Notes: bound from the bench top file
`timescale 1ns/1ps
module direct_frequency_cmd_sweep_sva #(parameter int direct_frequency_cmd_w = 32) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic continuous_sweep_cmd,
  input wire logic single_sweep_cmd,
  input wire logic sweep_off_cmd,
  input wire logic start_state_cmd,
  input wire logic stop_state_cmd,
  input wire logic direct_frequency_cmd,
  input wire logic ext_single_trigger,
  input wire logic [direct_frequency_cmd_w-1:0] direct_frequency,
  input wire logic sync_phase_in,
  input wire logic sync_clock_out,
  input wire logic sync_clock_oe,
  input wire logic sync_phase_oe,
  input wire logic phase_restart,
  input wire logic [direct_frequency_cmd_w-1:0] out_frequency,
  input wire logic marker_flag,
  input wire logic sweep_sync_flag,
  input wire logic [9:0] horizontal_drive,
  input wire logic program_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire run_cmd = continuous_sweep_cmd | single_sweep_cmd | sweep_off_cmd;
  wire quiet = !(run_cmd | start_state_cmd | stop_state_cmd);
  sequence s_rest;
    marker_flag && sweep_sync_flag && horizontal_drive == sweep_pkg::drive_zero;
  endsequence
  sequence s_end;
    marker_flag && sweep_sync_flag && (horizontal_drive == 10'h000 || horizontal_drive == 10'h3FF);
  endsequence
  a_off_rest: assert property (sweep_off_cmd |=> s_rest ##0 program_enable)
    else $error("sweep off did not restore outputs");
  a_cont_block: assert property (continuous_sweep_cmd && !sweep_off_cmd |=> !program_enable)
    else $error("continuous sweep left programming open");
  a_single_block: assert property (single_sweep_cmd && !sweep_off_cmd |=> !program_enable)
    else $error("single sweep left programming open");
  a_free_prog: assert property (program_enable && direct_frequency_cmd && quiet
    |=> out_frequency == $past(direct_frequency))
    else $error("direct frequency not applied");
  a_start_state: assert property (start_state_cmd && !run_cmd |=> s_end)
    else $error("start state outputs wrong");
  a_stop_state: assert property (stop_state_cmd && !run_cmd && !start_state_cmd |=> s_end)
    else $error("stop state outputs wrong");
  a_open_rest: assert property ($rose(program_enable) |-> s_rest)
    else $error("programming opened with outputs not at rest");
  a_ext_start: assert property ($fell(ext_single_trigger) && !sweep_off_cmd |-> ##[1:3] !program_enable)
    else $error("trigger edge did not start a sweep");
  a_link_pair: assert property (sync_clock_oe == sync_phase_oe)
    else $error("link enables differ");
  a_link_clock: assert property (sync_clock_oe && sync_clock_out |-> ##[1:4] (!sync_clock_out || !sync_clock_oe))
    else $error("link clock stuck high");
  a_slave_quiet: assert property ((!sync_phase_oe && !sync_phase_in)[*2] |-> !phase_restart)
    else $error("slave restarted without master pulse");
endmodule // direct_frequency_cmd_sweep_sva

// >>> testbench/sync_master_model.sv
// Purpose: master unit at the far end of the sync cable
// Assumes: link clock runs free at hclk/4
// Notes: phase pulse issued by the bench after setup
`timescale 1ns/1ps
module sync_master_model (
  input wire logic hclk,
  output logic sync_clock,
  output logic sync_phase
);
  logic [1:0] div;
  initial
  begin
    div = 2'h0;
    sync_clock = 1'b0;
    sync_phase = 1'b0;
  end
  always @(posedge hclk)
  begin
    div <= div + 2'h1;
    sync_clock <= div[1];
  end
  task automatic send_phase();
    sync_phase <= 1'b1;
    repeat (sweep_pkg::sync_pulse_cycles) @(posedge hclk);
    sync_phase <= 1'b0;
  endtask
endmodule // sync_master_model

// >>> testbench/test_frequency_sweep_controller.sv
// Purpose: directed bench for the sweep controller
// Assumes: zero wait state bus slave
// Notes: sweep time shortened through the time register
`timescale 1ns/1ps
module test_frequency_sweep_controller;
  logic hclk, hresetn, hsel, hwrite, ext_trig, hreadyout, hresp, sck_in, sph_in, sck_out, sck_oe, sph_out, sph_oe;
  logic restart, mkr, syn, pe;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, dfreq, out_f, f;
  logic [7:0] cmd;
  logic [9:0] drv;
  int n_fail, compares, k, c;
  direct_frequency_cmd_sweep u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .continuous_sweep_cmd(cmd[0]), .single_sweep_cmd(cmd[1]), .hold_resume_cmd(cmd[2]), .sweep_off_cmd(cmd[3]),
    .start_state_cmd(cmd[4]), .stop_state_cmd(cmd[5]), .host_phase_align_cmd(cmd[6]), .direct_frequency_cmd(cmd[7]),
    .ext_single_trigger(ext_trig), .direct_frequency(dfreq), .sync_clock_in(sck_in), .sync_phase_in(sph_in),
    .sync_clock_out(sck_out), .sync_clock_oe(sck_oe), .sync_phase_out(sph_out), .sync_phase_oe(sph_oe),
    .phase_restart(restart), .out_frequency(out_f), .marker_flag(mkr), .sweep_sync_flag(syn),
    .horizontal_drive(drv), .program_enable(pe));
  sync_master_model u_link (.hclk(hclk), .sync_clock(sck_in), .sync_phase(sph_in));
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h00000000);
    chk(n, e, rd);
  endtask
  task automatic pulse(input int b);
    cmd[b] <= 1'b1;
    @(posedge hclk);
    cmd <= 8'h00;
    @(posedge hclk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial
  begin
    #(25 * 20000);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, cmd, dfreq, n_fail, compares} = '0;
    hsize = 3'h2;
    ext_trig = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("start", sweep_pkg::off_start, sweep_pkg::rst_start);
    rdchk("center", sweep_pkg::off_center, 32'h0000D6D8);
    rdchk("span", sweep_pkg::off_span, 32'h00015F90);
    rdchk("unmapped", 8'h40, 32'h00000000);
    ahb(1'b1, sweep_pkg::off_start, 32'h00000010);
    rdchk("center", sweep_pkg::off_center, 32'h0000C358);
    rdchk("span", sweep_pkg::off_span, 32'h00018690);
    ahb(1'b1, sweep_pkg::off_stop, 32'h00000009);
    rdchk("odd center", sweep_pkg::off_center, 32'h0000000C);
    rdchk("span", sweep_pkg::off_span, 32'h00000007);
    ahb(1'b1, sweep_pkg::off_center, 32'h00000064);
    rdchk("start", sweep_pkg::off_start, 32'h00000068);
    rdchk("stop", sweep_pkg::off_stop, 32'h00000061);
    ahb(1'b1, sweep_pkg::off_span, 32'h00000014);
    rdchk("start", sweep_pkg::off_start, 32'h0000006E);
    rdchk("stop", sweep_pkg::off_stop, 32'h0000005A);
    $display("test range done");
    ahb(1'b1, sweep_pkg::off_start, 32'h000003E8);
    ahb(1'b1, sweep_pkg::off_stop, 32'h000007D0);
    ahb(1'b1, sweep_pkg::off_time, 32'h00000008);
    for (k = 0; k < 3; k++)
    begin
      ahb(1'b1, sweep_pkg::off_ctrl, 32'(k));
      pulse(sweep_pkg::cmd_single);
      chk("first leg", 32'h000003E8, out_f);
      c = 2;
      while (pe !== 1'b1 && c < 200)
      begin
        @(posedge hclk);
        #1;
        c++;
      end
      chk("sweep length", 1'b1, c >= (k == 1 ? 6 : 14) && c <= (k == 1 ? 11 : 19));
      chk("end outputs", 32'h00000C00, {20'h0, mkr, syn, drv});
    end
    dfreq <= 32'h00001234;
    pulse(7);
    chk("free direct_frequency_cmd", 32'h00001234, out_f);
    $display("test single done");
    ahb(1'b1, sweep_pkg::off_time, 32'h00000040);
    ahb(1'b1, sweep_pkg::off_ctrl, 32'h00000000);
    ahb(1'b1, sweep_pkg::off_cmd, 32'h00000001 << sweep_pkg::cmd_cont);
    #1;
    chk("blocked", 1'b0, pe);
    dfreq <= 32'h00000055;
    pulse(7);
    chk("direct_frequency_cmd kept", 1'b1, out_f >= 32'h3E8 && out_f <= 32'h7D0);
    pulse(sweep_pkg::cmd_hold);
    f = out_f;
    repeat (5) @(posedge hclk);
    chk("held", f, out_f);
    chk("held blocked", 1'b0, pe);
    pulse(sweep_pkg::cmd_hold);
    repeat (3) @(posedge hclk);
    chk("resumed", 1'b1, out_f > f);
    pulse(sweep_pkg::cmd_off);
    rdchk("off outputs", sweep_pkg::off_out, 32'h00000C00);
    chk("open", 1'b1, pe);
    pulse(sweep_pkg::cmd_start_st);
    chk("start direct_frequency_cmd", 32'h000003E8, out_f);
    chk("start drive", 10'h000, drv);
    pulse(sweep_pkg::cmd_stop_st);
    chk("stop direct_frequency_cmd", 32'h000007D0, out_f);
    chk("stop drive", 10'h3FF, drv);
    pulse(7);
    chk("leave drive", 10'h000, drv);
    ahb(1'b1, sweep_pkg::off_start, 32'h00000BB8);
    pulse(sweep_pkg::cmd_start_st);
    chk("down start drive", 10'h3FF, drv);
    pulse(sweep_pkg::cmd_stop_st);
    chk("down stop drive", 10'h000, drv);
    pulse(sweep_pkg::cmd_off);
    ext_trig <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("down sweep", 1'b1, out_f < 32'hBB8 && !pe);
    ext_trig <= 1'b1;
    pulse(sweep_pkg::cmd_off);
    $display("test states done");
    ahb(1'b1, sweep_pkg::off_ctrl, 32'h00000004);
    repeat (2) @(posedge hclk);
    chk("slave oe", 1'b0, sck_oe);
    pulse(sweep_pkg::cmd_phase);
    chk("own phase ignored", 1'b0, restart);
    u_link.send_phase();
    #1;
    chk("master phase", 1'b1, restart);
    ahb(1'b1, sweep_pkg::off_ctrl, 32'h00000000);
    repeat (2) @(posedge hclk);
    chk("master oe", 1'b1, sck_oe);
    $display("test link done");
    report_and_stop();
  end
endmodule // test_frequency_sweep_controller
bind direct_frequency_cmd_sweep direct_frequency_cmd_sweep_sva #(.direct_frequency_cmd_w(direct_frequency_cmd_w)) u_sva (.hclk, .hresetn, .continuous_sweep_cmd, .single_sweep_cmd,
  .sweep_off_cmd, .start_state_cmd, .stop_state_cmd, .direct_frequency_cmd, .ext_single_trigger, .direct_frequency,
  .sync_phase_in, .sync_clock_out, .sync_clock_oe, .sync_phase_oe, .phase_restart, .out_frequency, .marker_flag,
  .sweep_sync_flag, .horizontal_drive, .program_enable);
